/* core/duart_aux_pkg.sv */
/*
  Constants for the dual UART pin and strap control block: register
  offsets, field positions, reset values and timing counts.
  Assumes a single 250 MHz clock and an AHB-Lite register bus.
*/
package duart_aux_pkg;

  // ************************************************
  // Structure
  // ************************************************
  localparam int CHANNELS   = 2;       // Two UART channels
  localparam int DATA_W     = 8;       // Character width
  localparam int FIFO_DEPTH = 32;      // Bytes per FIFO
  localparam int SYNC_W     = 8;       // Pins passing the synchroniser

  // ************************************************
  // Register map, byte addresses
  // ************************************************
  localparam logic [5:0] REG_DATA   = 6'h00;  // W pushes tx, R pops rx
  localparam logic [5:0] REG_MCTL   = 6'h04;  // Modem control
  localparam logic [5:0] REG_STAT   = 6'h08;  // Channel status
  localparam logic [5:0] REG_PINS   = 6'h20;  // Global pin status
  localparam int         CH_SEL_BIT = 4;      // Channel B at +0x10

  // ************************************************
  // Fields
  // ************************************************
  localparam int         MCTL_IRQ_EN_BIT   = 3;
  localparam int         MCTL_LOOP_BIT     = 4;
  localparam int         MCTL_PRESCALE_BIT = 7;
  localparam logic [7:0] MCTL_RESET        = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;
  localparam logic [1:0] HTRANS_SEQ       = 2'h3;

  // Synchroniser bit positions
  localparam int SY_STYLE = 0;
  localparam int SY_RST   = 1;
  localparam int SY_STRAP = 2;
  localparam int SY_ISO   = 3;
  localparam int SY_CD    = 4;
  localparam int SY_RI    = 5;
  localparam int SY_RX0   = 6;

  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_PERIOD_PS = 4000;   // 250 MHz
  localparam int RST_MIN_PS    = 40000;  // 40 ns least reset pulse
  localparam int RST_MIN_CYC   = (RST_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_CNT_W     = 5;

endpackage

/* core/byte_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes push and pop come from logic on the same clock.
*/
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             flush,     // Synchronous clear
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data,
  output      logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];          // Storage
  logic [AW-1:0]    wr_q;                 // Write pointer
  logic [AW-1:0]    rd_q;                 // Read pointer
  logic [AW:0]      cnt_q;                // Fill level
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign level     = cnt_q;

  // Memory has no reset, only pointers and count do
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  // Pointers and count
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* core/duart_aux_ctrl.sv */
/*
  Pin, strap and per-channel control of a dual UART: bus style, reset
  qualification, prescaler strap with software override, bus isolation,
  channel B interrupt and aux pins, and per-channel 32-byte FIFOs.
  Assumes one 250 MHz clock; all pins are asynchronous to it and the
  register bus is AHB-Lite with this block as its only slave.
*/
module duart_aux_ctrl (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata,
  // Pins
  input  wire logic        bus_style_sel_in,     // High: separate strobes
  input  wire logic        reset_pin_in,         // Polarity per bus style
  input  wire logic        prescaler_strap,
  input  wire logic        bus_isolate_in,
  input  wire logic        carrier_detect_in_b_n,
  input  wire logic        ring_indicator_in_b_n,
  input  wire logic [1:0]  rx_in,
  output      logic [1:0]  tx_out,
  output      logic        irq_out_chan_b,
  output      logic        irq_out_chan_b_oe,
  output      logic        aux_output_chan_b_n,
  output      logic        strobe_mode_out,      // Host style in use
  output      logic [1:0]  prescale_div4,        // Per channel divide by 4
  output      logic        chip_reset_out        // Qualified reset active
);
  localparam int CH = duart_aux_pkg::CHANNELS;
  localparam int LW = $clog2(duart_aux_pkg::FIFO_DEPTH) + 1;

  // ************************************************
  // Pin synchroniser
  // ************************************************
  logic [duart_aux_pkg::SYNC_W-1:0] meta_q;   // First stage, read by sync_q only
  logic [duart_aux_pkg::SYNC_W-1:0] sync_q;   // Safe copies
  wire  [duart_aux_pkg::SYNC_W-1:0] pins_raw = {rx_in, ring_indicator_in_b_n,
    carrier_detect_in_b_n, bus_isolate_in, prescaler_strap, reset_pin_in,
    bus_style_sel_in};

  // Two flops before anything looks at a pin
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= pins_raw;
      sync_q <= meta_q;
    end
  end

  wire style_sep = sync_q[duart_aux_pkg::SY_STYLE];
  wire isolate   = sync_q[duart_aux_pkg::SY_ISO];
  assign strobe_mode_out = style_sep;

  // ************************************************
  // Reset pin qualification
  // ************************************************
  // Polarity follows bus style: high for strobes, low for direction style
  wire rst_pin_act = style_sep ? sync_q[duart_aux_pkg::SY_RST]
                               : ~sync_q[duart_aux_pkg::SY_RST];
  logic [duart_aux_pkg::RST_CNT_W-1:0] rst_cnt_q;  // Active-width counter
  logic                                chip_rst_q; // Qualified reset
  wire rst_long = (rst_cnt_q >= duart_aux_pkg::RST_CNT_W'(duart_aux_pkg::RST_MIN_CYC - 1));

  // Glitches shorter than the least pulse are ignored
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_cnt_q  <= '0;
      chip_rst_q <= 1'b1;
    end
    else if (!rst_pin_act)
    begin
      rst_cnt_q  <= '0;
      chip_rst_q <= 1'b0;
    end
    else
    begin
      if (!rst_long)
        rst_cnt_q <= rst_cnt_q + 1'b1;
      // Once taken, reset holds while the pin stays active; this also keeps
      // the block in reset until the synchroniser shows real pin levels
      chip_rst_q <= chip_rst_q | rst_long;
    end
  end
  assign chip_reset_out = chip_rst_q;

  // ************************************************
  // Prescaler strap
  // ************************************************
  logic strap_q;   // Strap caught during reset; high means divide by 1
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      strap_q <= 1'b0;
    else if (chip_rst_q)
      strap_q <= sync_q[duart_aux_pkg::SY_STRAP];
  end

  // ************************************************
  // AHB-Lite address phase capture
  // ************************************************
  wire  take = hsel & hready & htrans[1];
  logic       dp_wr_q;     // Write data phase pending
  logic [5:0] dp_addr_q;   // Captured byte address
  logic       dp_iso_q;    // Isolated at address phase
  wire  [5:0] a_off = {haddr[5], 1'b0, haddr[3:0]};
  wire        a_ch  = haddr[duart_aux_pkg::CH_SEL_BIT];
  wire  [5:0] w_off = {dp_addr_q[5], 1'b0, dp_addr_q[3:0]};
  wire        w_ch  = dp_addr_q[duart_aux_pkg::CH_SEL_BIT];

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= '0;
      dp_iso_q  <= 1'b0;
    end
    else
    begin
      dp_wr_q   <= take & hwrite;
      dp_addr_q <= haddr[5:0];
      dp_iso_q  <= isolate;
    end
  end

  // While isolated, nothing on the bus has any effect
  wire wr_ok = dp_wr_q & ~dp_iso_q & ~chip_rst_q;
  wire rd_ok = take & ~hwrite & ~isolate & ~chip_rst_q;

  // ************************************************
  // Per-channel registers and FIFOs
  // ************************************************
  logic [7:0]          mctl_q  [CH];   // Modem control per channel
  logic [CH-1:0]       ovr_q;          // Software override taken
  logic [CH-1:0]       rx_pop;
  logic [CH-1:0]       tx_push;
  logic [CH-1:0]       tx_valid;
  logic [CH-1:0]       rx_ready;
  logic [CH-1:0]       rx_valid;
  logic [CH-1:0]       tx_ready;
  logic [CH-1:0]       rx_line_q;      // Receive line seen outside reset
  logic [7:0]          tx_head [CH];
  logic [7:0]          rx_head [CH];
  logic [LW-1:0]       tx_lvl  [CH];
  logic [LW-1:0]       rx_lvl  [CH];
  logic [31:0]         stat    [CH];

  genvar c;
  generate
    for (c = 0; c < CH; c++)
    begin : g_ch
      wire sel_w = wr_ok & (w_ch == c[0]);
      wire mctl_w = sel_w & (w_off == duart_aux_pkg::REG_MCTL);
      wire loop   = mctl_q[c][duart_aux_pkg::MCTL_LOOP_BIT];
      wire move  = loop & tx_valid[c] & rx_ready[c];

      assign tx_push[c] = sel_w & (w_off == duart_aux_pkg::REG_DATA);
      assign rx_pop[c]  = rd_ok & (a_ch == c[0]) & (a_off == duart_aux_pkg::REG_DATA);

      // Own register set, reset by the qualified reset too
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          mctl_q[c]    <= duart_aux_pkg::MCTL_RESET;
          ovr_q[c]     <= 1'b0;
          rx_line_q[c] <= 1'b1;
        end
        else if (chip_rst_q)
        begin
          mctl_q[c]    <= duart_aux_pkg::MCTL_RESET;
          ovr_q[c]     <= 1'b0;
          rx_line_q[c] <= 1'b1;
        end
        else
        begin
          if (mctl_w)
          begin
            mctl_q[c] <= hwdata[7:0];
            ovr_q[c] <= 1'b1;
          end
          rx_line_q[c] <= sync_q[duart_aux_pkg::SY_RX0 + c];
        end
      end

      // Override bit: set means divide by 4; strap high means divide by 1
      assign prescale_div4[c] = ovr_q[c] ? mctl_q[c][duart_aux_pkg::MCTL_PRESCALE_BIT]
                                         : ~strap_q;

      // Transmit FIFO; loopback drains it into receive
      byte_fifo #(.WIDTH(duart_aux_pkg::DATA_W), .DEPTH(duart_aux_pkg::FIFO_DEPTH)) u_tx
      (
        .clk       (clk),
        .reset_n   (reset_n),
        .flush     (chip_rst_q),
        .in_valid  (tx_push[c]),
        .in_ready  (tx_ready[c]),
        .in_data   (hwdata[7:0]),
        .out_valid (tx_valid[c]),
        .out_ready (move),
        .out_data  (tx_head[c]),
        .level     (tx_lvl[c])
      );

      // Receive FIFO
      byte_fifo #(.WIDTH(duart_aux_pkg::DATA_W), .DEPTH(duart_aux_pkg::FIFO_DEPTH)) u_rx
      (
        .clk       (clk),
        .reset_n   (reset_n),
        .flush     (chip_rst_q),
        .in_valid  (move),
        .in_ready  (rx_ready[c]),
        .in_data   (tx_head[c]),
        .out_valid (rx_valid[c]),
        .out_ready (rx_pop[c]),
        .out_data  (rx_head[c]),
        .level     (rx_lvl[c])
      );

      // Status word: 19 zero bits above the 13 defined ones
      assign stat[c] = {19'h00000, rx_lvl[c], rx_line_q[c],
                        rx_valid[c], ~tx_ready[c], tx_valid[c], 1'b0,
                        prescale_div4[c], ovr_q[c]};

      // Transmit line idles high; held high in reset as no serialiser sits here
      assign tx_out[c] = 1'b1;
    end
  endgenerate

  // ************************************************
  // Read data
  // ************************************************
  // Carrier and ring only appear here, never steer channel logic
  wire [31:0] pins_word = {24'h000000, 2'b00, strap_q, isolate,
                           sync_q[duart_aux_pkg::SY_RI],
                           sync_q[duart_aux_pkg::SY_CD], chip_rst_q, style_sep};
  wire        r_ch = a_ch;
  wire [31:0] rd_mux =
      (a_off == duart_aux_pkg::REG_DATA) ? {24'h000000, rx_head[r_ch]} :
      (a_off == duart_aux_pkg::REG_MCTL) ? {24'h000000, mctl_q[r_ch]}  :
      (a_off == duart_aux_pkg::REG_STAT) ? stat[r_ch]                  :
      (haddr[5:0] == duart_aux_pkg::REG_PINS) ? pins_word : 32'h00000000;

  // Read data captured at the address phase, stands in the data phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hrdata <= 32'h00000000;
    else if (take & ~hwrite)
      hrdata <= (isolate | chip_rst_q) ? 32'h00000000 : rd_mux;
  end

  // ************************************************
  // Channel B interrupt and aux pins
  // ************************************************
  wire irq_en_b = mctl_q[1][duart_aux_pkg::MCTL_IRQ_EN_BIT];
  assign irq_out_chan_b      = rx_valid[1];
  assign irq_out_chan_b_oe   = irq_en_b;
  assign aux_output_chan_b_n = ~irq_en_b;

  // ************************************************
  // Checks
  // ************************************************
  logic [duart_aux_pkg::RST_CNT_W-1:0] act_run_q;  // Cycles pin stayed active
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      act_run_q <= '0;
    else if (!rst_pin_act)
      act_run_q <= '0;
    else if (act_run_q != '1)
      act_run_q <= act_run_q + 1'b1;
  end

  AST_IRQ_PINS: assert property (@(posedge clk) disable iff (!reset_n)
    (irq_out_chan_b_oe == mctl_q[1][duart_aux_pkg::MCTL_IRQ_EN_BIT]) &&
    (aux_output_chan_b_n == !irq_out_chan_b_oe))
    else $error("irq enable and aux pin disagree");
  // Pin level two edges back; the first two edges after reset are skipped
  AST_STYLE: assert property (@(posedge clk) disable iff (!reset_n)
    $past(reset_n, 2) |-> (strobe_mode_out == $past(bus_style_sel_in, 2)))
    else $error("bus style not following pin");
  AST_RST_POL: assert property (@(posedge clk) disable iff (!reset_n)
    (sync_q[duart_aux_pkg::SY_RST] != sync_q[duart_aux_pkg::SY_STYLE]) |=> (rst_cnt_q == '0))
    else $error("reset counted at inactive level");
  AST_RST_MIN: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(chip_rst_q) |-> act_run_q >= duart_aux_pkg::RST_CNT_W'(duart_aux_pkg::RST_MIN_CYC))
    else $error("reset taken before least width");
  AST_TX_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
    chip_rst_q |-> (tx_out == 2'b11))
    else $error("transmit not high in reset");
  AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    (!chip_rst_q && !$past(chip_rst_q)) |-> $stable(strap_q))
    else $error("strap changed outside reset");
  AST_PRESCALE: assert property (@(posedge clk) disable iff (!reset_n)
    !ovr_q[0] |-> (prescale_div4[0] == !strap_q))
    else $error("strap prescale wrong");
  // Written bit, not the register, is the reference
  AST_OVERRIDE: assert property (@(posedge clk) disable iff (!reset_n)
    g_ch[0].mctl_w |=>
      (prescale_div4[0] == $past(hwdata[duart_aux_pkg::MCTL_PRESCALE_BIT])))
    else $error("override not applied");
  AST_ISOLATE: assert property (@(posedge clk) disable iff (!reset_n)
    (dp_iso_q && !chip_rst_q) |-> (tx_push == 2'b00) ##1 $stable(mctl_q[1]))
    else $error("bus acted while isolated");
  AST_FIFO_CAP: assert property (@(posedge clk) disable iff (!reset_n)
    tx_lvl[1] <= LW'(duart_aux_pkg::FIFO_DEPTH))
    else $error("fifo over depth");

  COV_RESET: cover property (@(posedge clk) disable iff (!reset_n) $fell(chip_rst_q));
  COV_LOOP:  cover property (@(posedge clk) disable iff (!reset_n) rx_valid[0] ##1 rx_pop[0]);
  COV_FULL:  cover property (@(posedge clk) disable iff (!reset_n) !tx_ready[1]);
endmodule

/* verification/host_model.sv */
/*
  Host processor model: a single-word AHB-Lite master for the
  pin and strap control block, used through its xfer task.
  Assumes one slave whose hreadyout is fed back as hready.
*/
module host_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output      logic        hsel,
  output      logic [31:0] haddr,
  output      logic [1:0]  htrans,
  output      logic        hwrite,
  output      logic [2:0]  hsize,
  output      logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************
  // Idle bus at time zero
  // ************************************************
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // ************************************************
  // Transfers
  // ************************************************
  // Wait for an edge that samples hready high, bounded
  task automatic wt();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 64)
        testbench.hang();
      @(posedge clk);
    end
  endtask

  // One word; the aux pin is never used as a general output
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= duart_aux_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    // Read data taken at the edge closing the data phase
    q = hrdata;
  endtask
endmodule

/* verification/testbench.sv */
/*
  Self-checking bench for the dual UART pin and strap control block.
  Assumes the host model as bus master and a 250 MHz clock.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************
  // Signals
  // ************************************************
  logic        clk, reset_n, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, rx, tx_out, prescale_div4;
  logic [2:0]  hsize;
  logic        style, rpin, strap, iso, cd, ri;
  logic        irq, oe, aux_n, strobe_mode_out, chip_reset_out;
  int          n_errors, checks;
  // Channel B sits one select bit above channel A
  localparam logic [31:0] CH_B  = 32'h1 << duart_aux_pkg::CH_SEL_BIT;
  localparam logic [31:0] DAT_A = 32'(duart_aux_pkg::REG_DATA);
  localparam logic [31:0] MCTL_A = 32'(duart_aux_pkg::REG_MCTL);
  localparam logic [31:0] STA_A = 32'(duart_aux_pkg::REG_STAT);
  localparam logic [31:0] PINS  = 32'(duart_aux_pkg::REG_PINS);

  host_model host_u (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  duart_aux_ctrl dut_u (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .bus_style_sel_in(style),
    .reset_pin_in(rpin), .prescaler_strap(strap), .bus_isolate_in(iso),
    .carrier_detect_in_b_n(cd), .ring_indicator_in_b_n(ri), .rx_in(rx), .tx_out(tx_out),
    .irq_out_chan_b(irq), .irq_out_chan_b_oe(oe), .aux_output_chan_b_n(aux_n),
    .strobe_mode_out(strobe_mode_out), .prescale_div4(prescale_div4),
    .chip_reset_out(chip_reset_out));

  // Free-running 4 ns clock
  always #2 clk = ~clk;

  // ************************************************
  // Helpers
  // ************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // A bound ran out
  task automatic hang();
    n_errors++;
    close_out();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    host_u.xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    host_u.xfer(1'b0, a, 32'h0, r);
  endtask

  // Let edges pass, then look where outputs are settled
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Wait out internal reset, then the settling edges
  task automatic settle();
    int n;
    n = 0;
    pause(1);
    while (chip_reset_out !== 1'b0)
    begin
      n++;
      if (n > 64)
        hang();
      pause(1);
    end
    pause(4);
  endtask

  // Pulse longer than the 40 ns minimum, including sync delay
  task automatic pin_reset(input logic act);
    @(posedge clk);
    rpin <= act;
    pause(16);
    chk(chip_reset_out, 1'b1);
    chk(tx_out, 2'b11);
    @(posedge clk);
    rpin <= ~act;
    settle();
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_strap();
    chk(prescale_div4, 2'b00);
    @(posedge clk);
    strap <= 1'b0;
    pause(6);
    chk(prescale_div4, 2'b00);
    pin_reset(1'b1);
    chk(prescale_div4, 2'b11);
    wr(MCTL_A, 32'h0);
    pause(2);
    chk(prescale_div4, 2'b10);
    wr(MCTL_A, 32'h80);
    pause(2);
    chk(prescale_div4, 2'b11);
    @(posedge clk);
    strap <= 1'b1;
    pin_reset(1'b1);
    chk(prescale_div4, 2'b00);
    wr(mctl_b_addr(), 32'h80);
    pause(2);
    chk(prescale_div4, 2'b10);
  endtask

  function automatic logic [31:0] mctl_b_addr();
    return MCTL_A | CH_B;
  endfunction

  task automatic t_irq();
    wr(MCTL_A, 32'h08);
    pause(2);
    chk(oe, 1'b0);
    wr(mctl_b_addr(), 32'h08);
    pause(2);
    chk(oe, 1'b1);
    chk(aux_n, 1'b0);
    wr(MCTL_A, 32'h0);
    rd(mctl_b_addr(), q);
    chk(q[7:0], 8'h08);
    wr(mctl_b_addr(), 32'h0);
    pause(2);
    chk(oe, 1'b0);
    chk(aux_n, 1'b1);
  endtask

  task automatic t_fifo();
    for (int i = 0; i < 32; i++)
    begin
      if (i == 31)
      begin
        rd(STA_A, q);
        chk(q[4], 1'b0);
      end
      wr(DAT_A, 32'(i));
    end
    rd(STA_A, q);
    chk(q[4:3], 2'b11);
    wr(mctl_b_addr(), 32'h18);
    for (int i = 0; i < 32; i++)
      wr(dat_b_addr(), 32'h40 + 32'(i));
    pause(40);
    chk(irq, 1'b1);
    rd(STA_A | CH_B, q);
    chk(q[12:7], 6'd32);
    for (int i = 0; i < 32; i++)
    begin
      rd(dat_b_addr(), q);
      chk(q[7:0], 8'h40 + 8'(i));
    end
    pause(2);
    chk(irq, 1'b0);
    pin_reset(1'b1);
    rd(STA_A, q);
    chk(q[3], 1'b0);
    rd(mctl_b_addr(), q);
    chk(q, 32'h0);
  endtask

  function automatic logic [31:0] dat_b_addr();
    return DAT_A | CH_B;
  endfunction

  task automatic t_style();
    @(posedge clk);
    style <= 1'b0;
    rpin  <= 1'b1;
    pause(6);
    chk(strobe_mode_out, 1'b0);
    chk(chip_reset_out, 1'b0);
    wr(mctl_b_addr(), 32'h08);
    pin_reset(1'b0);
    rd(mctl_b_addr(), q);
    chk(q, 32'h0);
    chk(oe, 1'b0);
    @(posedge clk);
    style <= 1'b1;
    // Sync delay plus the least reset width before the pin counts
    pause(16);
    chk(strobe_mode_out, 1'b1);
    chk(chip_reset_out, 1'b1);
    @(posedge clk);
    rpin <= 1'b0;
    settle();
  endtask

  task automatic t_iso();
    @(posedge clk);
    iso <= 1'b1;
    pause(4);
    wr(mctl_b_addr(), 32'h08);
    pause(2);
    chk(oe, 1'b0);
    rd(PINS, q);
    chk(q, 32'h0);
    chk(hresp, 1'b0);
    @(posedge clk);
    iso <= 1'b0;
    cd  <= 1'b0;
    ri  <= 1'b0;
    rx  <= 2'b10;
    pause(4);
    rd(mctl_b_addr(), q);
    chk(q, 32'h0);
    rd(PINS, q);
    chk(q[3:2], 2'b00);
    chk(tx_out, 2'b11);
    chk(irq, 1'b0);
    rd(STA_A, q);
    chk(q[6], 1'b0);
    rd(STA_A | CH_B, q);
    chk(q[6], 1'b1);
    @(posedge clk);
    cd <= 1'b1;
    ri <= 1'b1;
    rx <= 2'b11;
  endtask

  // ************************************************
  // Main sequence
  // ************************************************
  initial
  begin
    clk      = 1'b0;
    reset_n  = 1'b0;
    style    = 1'b1;
    rpin     = 1'b0;
    strap    = 1'b1;
    iso      = 1'b0;
    cd       = 1'b1;
    ri       = 1'b1;
    rx       = 2'b11;
    n_errors = 0;
    checks   = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    t_strap();
    t_irq();
    t_fifo();
    t_style();
    t_iso();
    close_out();
  end
endmodule
